// File: pkg/dcfr_map.svh
// dcfr register map, field positions, reset values and sizes
`ifndef DCFR_MAP_SVH
`define DCFR_MAP_SVH
`define DCFR_IDX_CMP_B_LOW     14'h3013
`define DCFR_IDX_CMP_C_HIGH    14'h3014
`define DCFR_IDX_CMP_C_LOW     14'h3015
`define DCFR_IDX_FIFO_HIGH     14'h3016
`define DCFR_IDX_FIFO_LOW      14'h3017
`define DCFR_IDX_CMP_A_QUAL    14'h3018
`define DCFR_BIT_QUAL_ON       7
`define DCFR_BIT_QUAL_DIR      6
`define DCFR_QUAL_WR_MASK      8'hC0
`define DCFR_RST_BYTE          8'h00
`define DCFR_FIFO_DEPTH        8
`define DCFR_FIFO_AW           3
`define DCFR_RESP_OK           2'h0
`define DCFR_RESP_SLVERR       2'h2
`endif

// File: pkg/dcfr_pkg.sv
// dcfr shared types
package dcfr_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic        is_read;
  } dcfr_cpu_cycle_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } dcfr_trace_entry_t;
  typedef enum logic [1:0] {
    DCFR_RST_CLEAR,
    DCFR_RST_KEEP,
    DCFR_RST_NONE
  } dcfr_rst_kind_t;
endpackage

// File: hdl/dcfr_trace_mem.sv
// trace FIFO storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module dcfr_trace_mem #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic [W-1:0]       rd_data
);
  logic [W-1:0] mem_reg [D];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // write-through so an entry pushed while read keeps the head consistent
  always_ff @(posedge ref_clk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: hdl/dcfr_regs.sv
// comparator B/C compare bytes, trace FIFO read port, comparator A qualifier
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcfr_map.svh"
module dcfr_regs (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       rst_end_run,
  input  wire logic                       debug_module_on,
  input  wire logic                       trace_begin_sel,
  input  wire logic [15:0]                avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  output logic [1:0]                      avs_response,
  input  wire dcfr_pkg::dcfr_cpu_cycle_t  cpu_cycle,
  input  wire logic                       cmp_a_addr_hit,
  input  wire logic                       trace_event_only,
  input  wire dcfr_pkg::dcfr_trace_entry_t trace_in,
  output logic                            cmp_a_hit,
  output logic                            cmp_b_low_hit,
  output logic                            cmp_c_hit,
  output logic                            fifo_empty,
  output logic                            fifo_full
);
  logic [7:0]                  cmp_b_low_reg;
  logic [7:0]                  cmp_c_high_reg;
  logic [7:0]                  cmp_c_low_reg;
  logic                        qual_on_reg;
  logic                        qual_dir_reg;
  logic [`DCFR_FIFO_AW-1:0]    rd_ptr_reg;
  logic [`DCFR_FIFO_AW-1:0]    rd_ptr_next;
  logic [`DCFR_FIFO_AW-1:0]    wr_ptr_reg;
  logic [`DCFR_FIFO_AW:0]      count_reg;
  logic [15:0]                 head_word;
  dcfr_pkg::dcfr_rst_kind_t    rst_kind;
  logic                        req;
  logic                        done;
  logic                        wr_lane;
  logic [13:0]                 idx;
  logic                        mapped;
  logic                        pop;
  logic                        push;
  logic [7:0]                  rd_byte;
  logic [7:0]                  qual_byte;
  logic                        pop_due_reg;

  // classify the reset in force this cycle
  always_comb begin
    if (rst_n) begin
      rst_kind = dcfr_pkg::DCFR_RST_NONE;
    end else if (debug_module_on && !trace_begin_sel) begin
      rst_kind = dcfr_pkg::DCFR_RST_KEEP;
    end else if (rst_end_run) begin
      // contents undefined by contract; holding them is the cheapest choice
      rst_kind = dcfr_pkg::DCFR_RST_KEEP;
    end else begin
      rst_kind = dcfr_pkg::DCFR_RST_CLEAR;
    end
  end

  // bus decode; a request is served on the cycle waitrequest is low
  always_comb begin
    idx     = avs_address[15:2];
    req     = rst_n && (avs_read || avs_write);
    done    = req && !avs_waitrequest;
    wr_lane = done && avs_write && avs_byteenable[0];
    mapped  = (idx >= `DCFR_IDX_CMP_B_LOW) && (idx <= `DCFR_IDX_CMP_A_QUAL);
    pop     = done && pop_due_reg;
    push    = rst_n && trace_in.valid && !fifo_full;
  end

  always_comb begin
    qual_byte = `DCFR_RST_BYTE;
    qual_byte[`DCFR_BIT_QUAL_ON]  = qual_on_reg;
    qual_byte[`DCFR_BIT_QUAL_DIR] = qual_dir_reg;
  end

  always_comb begin
    case (idx)
      `DCFR_IDX_CMP_B_LOW: begin
        rd_byte = cmp_b_low_reg;
      end
      `DCFR_IDX_CMP_C_HIGH: begin
        rd_byte = cmp_c_high_reg;
      end
      `DCFR_IDX_CMP_C_LOW: begin
        rd_byte = cmp_c_low_reg;
      end
      `DCFR_IDX_FIFO_HIGH: begin
        rd_byte = (fifo_empty || trace_event_only) ? 8'h00 : head_word[15:8];
      end
      `DCFR_IDX_FIFO_LOW: begin
        rd_byte = fifo_empty ? 8'h00 : head_word[7:0];
      end
      `DCFR_IDX_CMP_A_QUAL: begin
        rd_byte = qual_byte;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // one wait cycle per request, then a single ready cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= `DCFR_RESP_OK;
    end else if (req && avs_waitrequest) begin
      avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      avs_response <= mapped ? `DCFR_RESP_OK : `DCFR_RESP_SLVERR;
    end
  end

  // a low read pops only if it returned a word when taken; empty lags a push
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pop_due_reg <= 1'b0;
    end else if (req && avs_waitrequest) begin
      pop_due_reg <= avs_read && (idx == `DCFR_IDX_FIFO_LOW) && !fifo_empty;
    end
  end

  // compare bytes
  always_ff @(posedge ref_clk) begin
    if (rst_kind == dcfr_pkg::DCFR_RST_CLEAR) begin
      cmp_b_low_reg  <= `DCFR_RST_BYTE;
      cmp_c_high_reg <= `DCFR_RST_BYTE;
      cmp_c_low_reg  <= `DCFR_RST_BYTE;
    end else if (wr_lane) begin
      case (idx)
        `DCFR_IDX_CMP_B_LOW: begin
          cmp_b_low_reg <= avs_writedata[7:0];
        end
        `DCFR_IDX_CMP_C_HIGH: begin
          cmp_c_high_reg <= avs_writedata[7:0];
        end
        `DCFR_IDX_CMP_C_LOW: begin
          cmp_c_low_reg <= avs_writedata[7:0];
        end
        default: begin
          cmp_b_low_reg <= cmp_b_low_reg;
        end
      endcase
    end
  end

  // qualifier: only bits 7 and 6 are storage, the rest never written
  always_ff @(posedge ref_clk) begin
    if (rst_kind == dcfr_pkg::DCFR_RST_CLEAR) begin
      qual_on_reg  <= 1'b0;
      qual_dir_reg <= 1'b0;
    end else if (wr_lane && (idx == `DCFR_IDX_CMP_A_QUAL)) begin
      qual_on_reg  <= avs_writedata[`DCFR_BIT_QUAL_ON];
      qual_dir_reg <= avs_writedata[`DCFR_BIT_QUAL_DIR];
    end
  end

  // address comparators, one bit of compare value per address bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmp_b_low_hit <= 1'b0;
      cmp_c_hit     <= 1'b0;
      cmp_a_hit     <= 1'b0;
    end else begin
      cmp_b_low_hit <= (cpu_cycle.addr[7:0] == cmp_b_low_reg);
      cmp_c_hit     <= (cpu_cycle.addr[15:8] == cmp_c_high_reg) &&
                       (cpu_cycle.addr[7:0] == cmp_c_low_reg);
      cmp_a_hit     <= cmp_a_addr_hit &&
                       (!qual_on_reg || (cpu_cycle.is_read == qual_dir_reg));
    end
  end

  // trace FIFO pointers; a full FIFO drops new entries
  always_comb begin
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst_kind == dcfr_pkg::DCFR_RST_CLEAR) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (rst_n) begin
      rd_ptr_reg <= rd_ptr_next;
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10: begin
          count_reg <= count_reg + 1'b1;
        end
        2'b01: begin
          count_reg <= count_reg - 1'b1;
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

  // flags set on the edge the count reaches 0 or 8 and clear one edge after it leaves, both straight from flops
  always_ff @(posedge ref_clk) begin
    if (rst_kind == dcfr_pkg::DCFR_RST_CLEAR) begin
      fifo_empty <= 1'b1;
      fifo_full  <= 1'b0;
    end else begin
      fifo_empty <= (count_reg == '0) || ((count_reg == 4'h1) && pop && !push);
      fifo_full  <= (count_reg == 4'h8) ||
                    ((count_reg == 4'h7) && push && !pop);
    end
  end

  // memory reads the next pointer so the head is fresh on the same edge the pop advances the pointer
  dcfr_trace_mem #(
    .W (16),
    .D (`DCFR_FIFO_DEPTH),
    .AW(`DCFR_FIFO_AW)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en  (push),
    .wr_addr(wr_ptr_reg),
    .wr_data(trace_in.word),
    .rd_addr(rd_ptr_next),
    .rd_data(head_word)
  );

  // checks
  logic [7:0] snap_c_high_reg;
  logic       prev_clear_reg;
  logic       prev_keep_reg;

  always_ff @(posedge ref_clk) begin
    if (rst_n) begin
      snap_c_high_reg <= cmp_c_high_reg;
    end
    prev_clear_reg <= (rst_kind == dcfr_pkg::DCFR_RST_CLEAR);
    prev_keep_reg  <= !rst_n && debug_module_on && !trace_begin_sel;
  end

  sequence s_read_at(logic [13:0] i);
    avs_read && (avs_address[15:2] == i) && avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  sequence s_write_at(logic [13:0] i);
    avs_write && avs_byteenable[0] && (avs_address[15:2] == i) && !avs_waitrequest;
  endsequence

  AST_CMP_B_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_write_at(`DCFR_IDX_CMP_B_LOW)
    |=> ({24'h00_0000, cmp_b_low_reg} == ($past(avs_writedata) & 32'h0000_00FF)))
    else $error("comparator B low byte not stored");

  AST_CMP_B_MISS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpu_cycle.addr[7:0] != cmp_b_low_reg) |=> !cmp_b_low_hit)
    else $error("comparator B low hit despite mismatch");

  AST_CMP_C_HIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpu_cycle.addr[15:8] != cmp_c_high_reg) |=> !cmp_c_hit)
    else $error("comparator C hit despite high byte mismatch");

  AST_CMP_C_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cpu_cycle.addr == {cmp_c_high_reg, cmp_c_low_reg}) |=> cmp_c_hit)
    else $error("comparator C full match missing");

  AST_RST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) && prev_clear_reg |-> (cmp_b_low_reg == 8'h00) &&
    (cmp_c_high_reg == 8'h00) && (cmp_c_low_reg == 8'h00) && !qual_on_reg && fifo_empty)
    else $error("registers not cleared by reset");

  AST_RST_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) && prev_keep_reg |-> cmp_c_high_reg == snap_c_high_reg)
    else $error("end-trace reset lost comparator C contents");

  AST_FIFO_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!fifo_empty && !trace_event_only) ##0 s_read_at(`DCFR_IDX_FIFO_HIGH)
    |-> avs_readdata == {24'h00_0000, $past(head_word[15:8])})
    else $error("FIFO high byte read wrong");

  AST_FIFO_HIGH_EVT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trace_event_only ##0 s_read_at(`DCFR_IDX_FIFO_HIGH) |-> avs_readdata == 32'h0)
    else $error("FIFO high byte not zero in event-only mode");

  AST_FIFO_POP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_read && (avs_address[15:2] == `DCFR_IDX_FIFO_LOW) && !avs_waitrequest &&
    !$past(fifo_empty)
    |=> rd_ptr_reg == $past(rd_ptr_reg) + 3'h1 ##1 avs_waitrequest)
    else $error("low byte read did not advance FIFO");

  AST_QUAL_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !qual_on_reg && cmp_a_addr_hit |=> cmp_a_hit)
    else $error("comparator A blocked although direction ignored");

  AST_QUAL_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    qual_on_reg && (cpu_cycle.is_read != qual_dir_reg) |=> !cmp_a_hit)
    else $error("comparator A matched wrong direction");

  AST_QUAL_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_at(`DCFR_IDX_CMP_A_QUAL) |-> (avs_readdata & ~32'h0000_00C0) == 32'h0)
    else $error("qualifier reserved bits not zero");
endmodule
`default_nettype wire

// File: verif/dcfr_cpu_model.sv
// cpu bus and trace source model feeding the register block
`timescale 1ns/1ps
`default_nettype none
module dcfr_cpu_model (
  input  wire logic                      ref_clk,
  input  wire logic                      push,
  input  wire logic [15:0]               word,
  input  wire logic [15:0]               addr,
  input  wire logic                      is_read,
  output var dcfr_pkg::dcfr_cpu_cycle_t   cpu_cycle,
  output var dcfr_pkg::dcfr_trace_entry_t trace_in
);
  assign cpu_cycle = '{addr: addr, is_read: is_read};
  // idle word flips so a stale word never passes for fresh data
  always_ff @(posedge ref_clk) begin
    trace_in.valid <= push;
    trace_in.word  <= push ? word : ~trace_in.word;
  end
endmodule
`default_nettype wire

// File: verif/debug_compare_fifo_regs_tb_top.sv
// self-checking bench for the dcfr register block
`timescale 1ns/1ps
`default_nettype none
`include "dcfr_map.svh"
module debug_compare_fifo_regs_tb_top;
  logic        ref_clk = 0, rst_n = 0, rst_end_run = 0, debug_module_on = 0;
  logic        trace_begin_sel = 0, avs_read = 0, avs_write = 0, push = 0, is_read = 0;
  logic        cmp_a_addr_hit = 0, trace_event_only = 0;
  logic        avs_waitrequest, cmp_a_hit, cmp_b_low_hit, cmp_c_hit, fifo_empty, fifo_full;
  logic [15:0] avs_address = 0, word = 0, addr = 0, c;
  logic [31:0] avs_writedata = 0, avs_readdata, seed;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [1:0]  avs_response, rd_resp;
  logic [7:0]  rd_byte, b, x;
  logic [15:0] q[$];
  int          n_mismatch = 0, num_checks = 0, cycles = 0;
  dcfr_pkg::dcfr_cpu_cycle_t   cpu_cycle;
  dcfr_pkg::dcfr_trace_entry_t trace_in;

  dcfr_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rst_end_run(rst_end_run),
    .debug_module_on(debug_module_on), .trace_begin_sel(trace_begin_sel),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .cpu_cycle(cpu_cycle), .cmp_a_addr_hit(cmp_a_addr_hit),
    .trace_event_only(trace_event_only), .trace_in(trace_in), .cmp_a_hit(cmp_a_hit),
    .cmp_b_low_hit(cmp_b_low_hit), .cmp_c_hit(cmp_c_hit), .fifo_empty(fifo_empty),
    .fifo_full(fifo_full));
  dcfr_cpu_model u_cpu (.ref_clk(ref_clk), .push(push), .word(word), .addr(addr),
    .is_read(is_read), .cpu_cycle(cpu_cycle), .trace_in(trace_in));

  initial forever #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_a(input logic [7:0] q8, input logic r, input logic h);
    return h && (!q8[7] || (r == q8[6]));
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low; no latency assumed
  task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= {idx, 2'h0};
    avs_writedata <= {24'h000000, d};
    // only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_byte = avs_readdata[7:0];
    rd_resp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [13:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk8(nm, e, rd_byte);
  endtask
  task automatic do_reset(input logic keep);
    @(posedge ref_clk);
    debug_module_on <= keep;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic cmp(input logic [15:0] a, input logic r, input logic h);
    @(posedge ref_clk);
    addr <= a;
    is_read <= r;
    cmp_a_addr_hit <= h;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic push_word(input logic [15:0] w);
    @(posedge ref_clk);
    push <= 1'b1;
    word <= w;
    @(posedge ref_clk);
    push <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    seed = 32'hD51167C8;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk("reset byte", 14'h3013 + 14'(i), 8'h00);
    bus(1'b0, 14'h3019, 8'h00);
    chk8("unmapped resp", {6'h00, `DCFR_RESP_SLVERR}, {6'h00, rd_resp});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      b = seed[7:0];
      c = seed[23:8];
      x = {i[1:0], seed[29:24]};
      bus(1'b1, `DCFR_IDX_CMP_B_LOW, b);
      bus(1'b1, `DCFR_IDX_CMP_C_HIGH, c[15:8]);
      bus(1'b1, `DCFR_IDX_CMP_C_LOW, c[7:0]);
      bus(1'b1, `DCFR_IDX_CMP_A_QUAL, x);
      rdchk("cmp b low", `DCFR_IDX_CMP_B_LOW, b);
      rdchk("cmp c high", `DCFR_IDX_CMP_C_HIGH, c[15:8]);
      rdchk("cmp c low", `DCFR_IDX_CMP_C_LOW, c[7:0]);
      rdchk("qualifier", `DCFR_IDX_CMP_A_QUAL, x & 8'hC0);
      cmp({seed[15:8], b}, 1'b0, 1'b1);
      chk1("b low hit", 1'b1, cmp_b_low_hit);
      chk1("a hit wr", exp_a(x, 1'b0, 1'b1), cmp_a_hit);
      cmp(c, 1'b1, 1'b1);
      chk1("c hit", 1'b1, cmp_c_hit);
      chk1("a hit rd", exp_a(x, 1'b1, 1'b1), cmp_a_hit);
      cmp(c ^ 16'h8000, 1'b1, 1'b0);
      chk1("c high miss", 1'b0, cmp_c_hit);
      chk1("a addr miss", 1'b0, cmp_a_hit);
      cmp(c ^ 16'h0001, 1'b0, 1'b1);
      chk1("c low miss", 1'b0, cmp_c_hit);
      chk1("b low cmp", (c[7:0] ^ 8'h01) == b, cmp_b_low_hit);
    end
    // byte lane off: the write must leave the byte alone
    avs_byteenable <= 4'h0;
    bus(1'b1, `DCFR_IDX_CMP_B_LOW, ~b);
    avs_byteenable <= 4'hF;
    rdchk("masked write", `DCFR_IDX_CMP_B_LOW, b);
    do_reset(1'b1);
    rdchk("kept b low", `DCFR_IDX_CMP_B_LOW, b);
    rdchk("kept c high", `DCFR_IDX_CMP_C_HIGH, c[15:8]);
    rdchk("kept qualifier", `DCFR_IDX_CMP_A_QUAL, x & 8'hC0);
    // debug on but begin selected: not an end-trace reset, so it clears
    trace_begin_sel <= 1'b1;
    do_reset(1'b1);
    rdchk("cleared b low", `DCFR_IDX_CMP_B_LOW, 8'h00);
    rdchk("cleared c low", `DCFR_IDX_CMP_C_LOW, 8'h00);
    rdchk("cleared qualifier", `DCFR_IDX_CMP_A_QUAL, 8'h00);
    // ninth push lands on a full fifo and is dropped
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      push_word(seed[15:0]);
      if (i < 8) q.push_back(seed[15:0]);
    end
    repeat (2) @(posedge ref_clk);
    chk1("fifo full", 1'b1, fifo_full);
    for (int i = 0; i < 8; i++) begin
      trace_event_only <= (i >= 6);
      if (i != 7) rdchk("fifo high", `DCFR_IDX_FIFO_HIGH, (i >= 6) ? 8'h00 : q[i][15:8]);
      rdchk("fifo low", `DCFR_IDX_FIFO_LOW, q[i][7:0]);
    end
    repeat (2) @(posedge ref_clk);
    chk1("fifo empty", 1'b1, fifo_empty);
    rdchk("empty low", `DCFR_IDX_FIFO_LOW, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
